// ---- design/adc_sample_convert_sequencer.sv ----
// sample/convert sequencer with its AHB-Lite register slave
// assumes the converter runs on clk: convStart is answered later by one convDone
//
// Notes on behaviour
// - alternate on: first set, then second, repeating
// - split buffer: halves swap after each interrupt
// - single buffer: fill words 0 to 15, restart
// - interrupt after interval field plus one sequences
// - channel count 01 two channels, 1x four
// - joint mode: sample together, convert in order
// - joint auto: resample after whole group converts
// - sequential auto: channel resamples after own conversion
// - no auto: software sets acquire each time
// - channel 0 positive code selects that input
// - channel 0 negative: reference or input 1
// - trio positive: inputs 0-2 or 3-5
// - trio negative: reference, 6-8 or 9-11
// - two channels, alternate, four sequences: eight words
// - half flag toggles after each interrupt with split buffer on
// - clearing acquire in software starts conversion
// - done flag set when sequence finishes
// - alternate off: always first set
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/100ps
module adc_sample_convert_sequencer (
    input wire logic clk,                         // 100 MHz conversion clock
    input wire logic arst_n,                      // async reset, low
    input wire logic hsel,                        // AHB slave select
    input wire logic [31:0] haddr,                // AHB address
    input wire logic [1:0] htrans,                // AHB transfer type
    input wire logic hwrite,                      // AHB write
    input wire logic [2:0] hsize,                 // AHB size
    input wire logic [31:0] hwdata,               // AHB write data
    input wire logic hready,                      // AHB bus ready
    output logic hreadyout,                       // AHB slave ready
    output logic hresp,                           // AHB response
    output logic [31:0] hrdata,                   // AHB read data
    output logic convStart,                       // start one conversion
    output logic [1:0] convChannel,               // channel to convert
    input wire logic convDone,                    // conversion finished
    input wire logic [9:0] convResult,            // conversion result
    output logic [3:0] sampleHold,                // per channel sampling
    output adc_seq_pkg::route_s [3:0] routes      // analog input routing
);

    // ****************************************************************
    // state
    // ****************************************************************
    adc_seq_pkg::ctrl_s ctrl, next_ctrl;
    adc_seq_pkg::set_sel_s firstInputSet, next_firstInputSet;
    adc_seq_pkg::set_sel_s secondInputSet, next_secondInputSet;
    adc_seq_pkg::seq_state_e state, next_state;
    logic convIrqFlag, next_convIrqFlag;
    logic doneFlag, next_doneFlag;
    logic activeHalfFlag, next_activeHalfFlag;
    logic altPhase, next_altPhase;
    logic [1:0] seqChan, next_seqChan;
    logic [1:0] next_convChannel;
    logic [3:0] ptr, next_ptr;
    logic [3:0] seqCount, next_seqCount;
    logic next_convStart;
    logic [3:0] next_sampleHold;
    logic wrPend, next_wrPend;
    logic [7:0] busAddr, next_busAddr;
    logic [31:0] next_hrdata;
    logic accept, ctrlWrite, selWrite, statusWrite, swTrigger;
    logic ramWe, seqEnd, groupEnd, irqEvent, busyNext;
    logic [3:0] enMask, wrIdx, busyMask;
    logic [1:0] lastChan;
    logic [9:0] ramRdData;
    adc_seq_pkg::set_sel_s setInUse;

    // ****************************************************************
    // bus address phase and register read
    // ****************************************************************
    function automatic logic [31:0] readReg(input logic [7:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a == adc_seq_pkg::OFF_CTRL) begin
            v[11:0] = {ctrl[10:7], 1'b0, ctrl[6:0]};
        end else if (a == adc_seq_pkg::OFF_SELECT) begin
            v[adc_seq_pkg::P_SET_FIRST +: 8] = firstInputSet;
            v[adc_seq_pkg::P_SET_SECOND +: 8] = secondInputSet;
        end else if (a == adc_seq_pkg::OFF_STATUS) begin
            v[adc_seq_pkg::P_IRQ] = convIrqFlag;
            v[adc_seq_pkg::P_DONE] = doneFlag;
            v[adc_seq_pkg::P_HALF] = activeHalfFlag;
            v[adc_seq_pkg::P_BUSY] = (state != adc_seq_pkg::ST_IDLE);
            v[adc_seq_pkg::P_SETUSE] = altPhase;
        end else if (a[7:6] == adc_seq_pkg::OFF_RESULT[7:6]) begin
            v[9:0] = ramRdData;
        end
        return v;
    endfunction : readReg

    always_comb begin
        accept = hsel && htrans[1] && hready;
        next_wrPend = accept && hwrite && (hsize == 3'h2);
        next_busAddr = accept ? haddr[7:0] : busAddr;
        next_hrdata = (accept && !hwrite) ? readReg(haddr[7:0]) : adc_seq_pkg::RDATA_RESET;
        ctrlWrite = wrPend && (busAddr == adc_seq_pkg::OFF_CTRL);
        selWrite = wrPend && (busAddr == adc_seq_pkg::OFF_SELECT);
        statusWrite = wrPend && (busAddr == adc_seq_pkg::OFF_STATUS);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wrPend <= 1'b0;
            busAddr <= 8'h00;
            hrdata <= adc_seq_pkg::RDATA_RESET;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            wrPend <= next_wrPend;
            busAddr <= next_busAddr;
            hrdata <= next_hrdata;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ****************************************************************
    // sequencer
    // ****************************************************************
    always_comb begin
        unique case (ctrl.channelCountSel)
            2'b00: begin enMask = 4'h1; lastChan = 2'h0; end
            2'b01: begin enMask = 4'h3; lastChan = 2'h1; end
            default: begin enMask = 4'hF; lastChan = 2'h3; end
        endcase
        wrIdx = ctrl.splitResultBuffer ? {activeHalfFlag, ptr[2:0]} : ptr;
        next_ctrl = ctrl;
        next_firstInputSet = firstInputSet;
        next_secondInputSet = secondInputSet;
        next_state = state;
        next_convIrqFlag = convIrqFlag;
        next_doneFlag = doneFlag;
        next_activeHalfFlag = activeHalfFlag;
        next_altPhase = altPhase;
        next_seqChan = seqChan;
        next_convChannel = convChannel;
        next_ptr = ptr;
        next_seqCount = seqCount;
        next_convStart = 1'b0;
        ramWe = 1'b0;
        seqEnd = 1'b0;
        groupEnd = 1'b0;
        irqEvent = 1'b0;
        swTrigger = ctrlWrite && ctrl.acquireBit && !hwdata[adc_seq_pkg::P_ACQUIRE];
        if (ctrlWrite) begin
            next_ctrl = {hwdata[11:8], hwdata[6:0]};
        end
        if (selWrite) begin
            next_firstInputSet = hwdata[adc_seq_pkg::P_SET_FIRST +: 8];
            next_secondInputSet = hwdata[adc_seq_pkg::P_SET_SECOND +: 8];
        end
        // clears come first so a hardware set in the same cycle wins
        if (statusWrite && hwdata[adc_seq_pkg::P_IRQ]) begin
            next_convIrqFlag = 1'b0;
        end
        if (statusWrite && hwdata[adc_seq_pkg::P_DONE]) begin
            next_doneFlag = 1'b0;
        end
        unique case (state)
            adc_seq_pkg::ST_IDLE: begin
                if (swTrigger) begin
                    next_state = adc_seq_pkg::ST_START;
                    next_convChannel = ctrl.jointAcquireMode ? 2'h0 : seqChan;
                    next_convStart = 1'b1;
                end
            end
            adc_seq_pkg::ST_START: begin
                next_state = adc_seq_pkg::ST_WAIT;
            end
            adc_seq_pkg::ST_WAIT: begin
                if (convDone) begin
                    ramWe = 1'b1;
                    next_ptr = ctrl.splitResultBuffer ? {1'b0, ptr[2:0] + 3'h1} : ptr + 4'h1;
                    groupEnd = (convChannel == lastChan);
                    if (ctrl.jointAcquireMode && !groupEnd) begin
                        next_convChannel = convChannel + 2'h1;
                        next_state = adc_seq_pkg::ST_START;
                        next_convStart = 1'b1;
                    end else begin
                        seqEnd = 1'b1;
                        next_state = adc_seq_pkg::ST_IDLE;
                        next_doneFlag = 1'b1;
                        next_seqChan = groupEnd ? 2'h0 : seqChan + 2'h1;
                        if (groupEnd) begin
                            next_altPhase = !altPhase;
                        end
                        if (ctrl.autoAcquire) begin
                            next_ctrl.acquireBit = 1'b1;
                        end
                        if (seqCount == ctrl.irqIntervalCount) begin
                            irqEvent = 1'b1;
                            next_convIrqFlag = 1'b1;
                            next_seqCount = adc_seq_pkg::COUNT_RESET;
                            next_ptr = adc_seq_pkg::PTR_RESET;
                            if (ctrl.splitResultBuffer) begin
                                next_activeHalfFlag = !activeHalfFlag;
                            end
                        end else begin
                            next_seqCount = seqCount + 4'h1;
                        end
                    end
                end
            end
            default: begin
                next_state = adc_seq_pkg::ST_IDLE;
            end
        endcase
        if (!next_ctrl.alternateSetEnable) begin
            next_altPhase = 1'b0;
        end
        busyNext = (next_state != adc_seq_pkg::ST_IDLE);
        busyMask = busyNext ? 4'(1 << next_convChannel) : 4'h0;
        if (next_ctrl.jointAcquireMode) begin
            next_sampleHold = enMask & {4{next_ctrl.acquireBit && !busyNext}};
        end else begin
            // with auto acquire only the converting channel stops and the others keep charging; without it all stop
            next_sampleHold = enMask & ~busyMask
                & {4{next_ctrl.acquireBit || (next_ctrl.autoAcquire && busyNext)}};
        end
        setInUse = altPhase ? secondInputSet : firstInputSet;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl <= adc_seq_pkg::CTRL_RESET;
            firstInputSet <= adc_seq_pkg::SEL_RESET;
            secondInputSet <= adc_seq_pkg::SEL_RESET;
            state <= adc_seq_pkg::ST_IDLE;
            convIrqFlag <= 1'b0;
            doneFlag <= 1'b0;
            activeHalfFlag <= 1'b0;
            altPhase <= 1'b0;
            seqChan <= 2'h0;
            convChannel <= 2'h0;
            ptr <= adc_seq_pkg::PTR_RESET;
            seqCount <= adc_seq_pkg::COUNT_RESET;
            convStart <= 1'b0;
            sampleHold <= 4'h0;
        end else begin
            ctrl <= next_ctrl;
            firstInputSet <= next_firstInputSet;
            secondInputSet <= next_secondInputSet;
            state <= next_state;
            convIrqFlag <= next_convIrqFlag;
            doneFlag <= next_doneFlag;
            activeHalfFlag <= next_activeHalfFlag;
            altPhase <= next_altPhase;
            seqChan <= next_seqChan;
            convChannel <= next_convChannel;
            ptr <= next_ptr;
            seqCount <= next_seqCount;
            convStart <= next_convStart;
            sampleHold <= next_sampleHold;
        end
    end

    // ****************************************************************
    // storage and routing
    // ****************************************************************
    result_ram #(
        .DEPTH(adc_seq_pkg::RAM_DEPTH),
        .WIDTH(adc_seq_pkg::RES_W)
    ) u_ram (
        .clk(clk),
        .arst_n(arst_n),
        .we(ramWe),
        .wrIdx(wrIdx),
        .wrData(convResult),
        .rdIdx(haddr[5:2]),
        .rdData(ramRdData)
    );

    input_router u_router (
        .clk(clk),
        .arst_n(arst_n),
        .sel(setInUse),
        .routes(routes)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [4:0] seqSinceIrq;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            seqSinceIrq <= 5'h00;
        end else if (irqEvent) begin
            seqSinceIrq <= 5'h00;
        end else if (seqEnd) begin
            seqSinceIrq <= seqSinceIrq + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    a_irq_interval: assert property (irqEvent
        |-> seqSinceIrq == {1'b0, ctrl.irqIntervalCount})
        else $error("interrupt not after interval plus one sequences");
    a_irq_sticky: assert property ($fell(convIrqFlag)
        |-> $past(statusWrite && hwdata[0]))
        else $error("interrupt flag dropped without software clear");
    a_half_toggle: assert property (irqEvent && ctrl.splitResultBuffer
        |=> activeHalfFlag != $past(activeHalfFlag) && ptr == 4'h0)
        else $error("buffer half not swapped after interrupt");
    a_count_restart: assert property (irqEvent |=> seqCount == 4'h0)
        else $error("sequence count not restarted");
    a_trigger_start: assert property (state == adc_seq_pkg::ST_IDLE && swTrigger
        |=> convStart ##1 !convStart)
        else $error("clearing acquire did not start one conversion");
    a_joint_order: assert property (state == adc_seq_pkg::ST_WAIT && convDone
        && ctrl.jointAcquireMode && convChannel != lastChan
        |=> convStart && convChannel == $past(convChannel) + 2'h1)
        else $error("joint group not converted in channel order");
    a_no_auto: assert property (seqEnd && !ctrl.autoAcquire && !ctrlWrite
        |=> !ctrl.acquireBit)
        else $error("sampling resumed without auto acquire");
    a_auto_resample: assert property (seqEnd && ctrl.autoAcquire |=> ctrl.acquireBit)
        else $error("auto acquire did not resume sampling");
    a_joint_hold: assert property (ctrl.jointAcquireMode && state == adc_seq_pkg::ST_WAIT
        |-> sampleHold == 4'h0)
        else $error("joint mode sampled during conversions");
    a_seq_own: assert property (!ctrl.jointAcquireMode && state == adc_seq_pkg::ST_WAIT
        |-> !sampleHold[convChannel])
        else $error("converting channel still sampling");
    a_done_set: assert property (seqEnd |=> doneFlag)
        else $error("done flag not set at sequence end");
    a_alt_off: assert property (!ctrl.alternateSetEnable |-> !altPhase)
        else $error("second set used with alternation off");

    c_split_irq: cover property (irqEvent && ctrl.splitResultBuffer);
    c_alt_second: cover property (seqEnd && altPhase);
    c_seq_conv: cover property (convDone && !ctrl.jointAcquireMode && ctrl.autoAcquire);
    c_joint_four: cover property (convDone && ctrl.jointAcquireMode && convChannel == 2'h3);

endmodule : adc_sample_convert_sequencer

// ---- design/adc_seq_pkg.sv ----
// constants, field layouts and carrier types of the sample/convert sequencer
// assumes a single 100 MHz clock and AHB-Lite register access
package adc_seq_pkg;

    // ****************************************************************
    // register byte offsets
    // ****************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_SELECT = 8'h04;
    localparam logic [7:0] OFF_STATUS = 8'h08;
    localparam logic [7:0] OFF_RESULT = 8'h40;

    // ****************************************************************
    // control word bit positions
    // ****************************************************************
    localparam int P_ACQUIRE = 0;
    localparam int P_AUTO = 1;
    localparam int P_JOINT = 2;
    localparam int P_CHCOUNT = 3;
    localparam int P_SPLIT = 5;
    localparam int P_ALT = 6;
    localparam int P_INTERVAL = 8;

    // ****************************************************************
    // status word bit positions
    // ****************************************************************
    localparam int P_IRQ = 0;
    localparam int P_DONE = 1;
    localparam int P_HALF = 2;
    localparam int P_BUSY = 3;
    localparam int P_SETUSE = 4;

    // select word: first set in low byte, second set in next byte
    localparam int P_SET_FIRST = 0;
    localparam int P_SET_SECOND = 8;

    // ****************************************************************
    // sizes and reset values
    // ****************************************************************
    localparam int NUM_CH = 4;
    localparam int RAM_DEPTH = 16;
    localparam int RES_W = 10;
    localparam logic [3:0] PTR_RESET = 4'h0;
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_WAIT = 2'b10
    } seq_state_e;

    typedef struct packed {
        logic [3:0] irqIntervalCount;
        logic alternateSetEnable;
        logic splitResultBuffer;
        logic [1:0] channelCountSel;
        logic jointAcquireMode;
        logic autoAcquire;
        logic acquireBit;
    } ctrl_s;

    typedef struct packed {
        logic [1:0] chTrioNegSel;
        logic chTrioPosSel;
        logic ch0NegSel;
        logic [3:0] ch0PosSel;
    } set_sel_s;

    typedef struct packed {
        logic negIsRef;
        logic [3:0] negInput;
        logic [3:0] posInput;
    } route_s;

    localparam ctrl_s CTRL_RESET = '0;
    localparam set_sel_s SEL_RESET = '0;
    localparam route_s ROUTE_RESET = 9'h100;

endpackage : adc_seq_pkg

// ---- design/input_router.sv ----
// maps one input-select set onto the analog inputs of the four sample/holds
// assumes the selected set is stable while a channel samples
`timescale 1ns/100ps
module input_router (
    input wire logic clk,                             // conversion clock
    input wire logic arst_n,                          // async reset, low
    input wire adc_seq_pkg::set_sel_s sel,            // set in use
    output adc_seq_pkg::route_s [3:0] routes          // per channel routing
);

    adc_seq_pkg::route_s [3:0] next_routes;

    always_comb begin
        next_routes[0].posInput = sel.ch0PosSel;
        next_routes[0].negIsRef = !sel.ch0NegSel;
        next_routes[0].negInput = sel.ch0NegSel ? 4'h1 : 4'h0;
    end

    // ****************************************************************
    // trio channels share one pair of select fields
    // ****************************************************************
    for (genvar k = 1; k < adc_seq_pkg::NUM_CH; k++) begin : g_trio
        always_comb begin
            next_routes[k].posInput = sel.chTrioPosSel ? 4'(k + 2) : 4'(k - 1);
            next_routes[k].negIsRef = !sel.chTrioNegSel[1];
            if (!sel.chTrioNegSel[1]) begin
                next_routes[k].negInput = 4'h0;
            end else if (sel.chTrioNegSel[0]) begin
                next_routes[k].negInput = 4'(k + 8);
            end else begin
                next_routes[k].negInput = 4'(k + 5);
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            routes <= {4{adc_seq_pkg::ROUTE_RESET}};
        end else begin
            routes <= next_routes;
        end
    end

    a_route_ch0: assert property (@(posedge clk) disable iff (!arst_n)
        routes[0].posInput == $past(sel.ch0PosSel))
        else $error("channel 0 positive route does not follow its code");
    a_route_trio: assert property (@(posedge clk) disable iff (!arst_n)
        $past(sel.chTrioNegSel) == 2'h3 |-> routes[3].negInput == 4'hB)
        else $error("trio negative route wrong for code 11");

endmodule : input_router

// ---- design/result_ram.sv ----
// result storage: flip-flop words written by the sequencer, read by the bus
// assumes one write at a time and a combinational read index
`timescale 1ns/100ps
module result_ram #(
    parameter int DEPTH = 16,
    parameter int WIDTH = 10
) (
    input wire logic clk,                       // conversion clock
    input wire logic arst_n,                    // async reset, low
    input wire logic we,                        // write strobe
    input wire logic [$clog2(DEPTH)-1:0] wrIdx, // write index
    input wire logic [WIDTH-1:0] wrData,        // result to store
    input wire logic [$clog2(DEPTH)-1:0] rdIdx, // read index
    output logic [WIDTH-1:0] rdData             // stored word
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];

    for (genvar i = 0; i < DEPTH; i++) begin : g_word
        always_comb begin
            next_mem[i] = (we && wrIdx == i) ? wrData : mem[i];
        end
        always_ff @(posedge clk or negedge arst_n) begin
            if (!arst_n) begin
                mem[i] <= '0;
            end else begin
                mem[i] <= next_mem[i];
            end
        end
    end

    assign rdData = mem[rdIdx];

    a_ram_write: assert property (@(posedge clk) disable iff (!arst_n)
        we |=> mem[$past(wrIdx)] == $past(wrData))
        else $error("result word not stored at its index");

endmodule : result_ram

// ---- verification/conv_model.sv ----
// converter model: one done pulse per start, latency alternating short and long
// assumes convChannel and routes hold from convStart until convDone
`timescale 1ns/100ps
module conv_model (
    input wire logic clk, // clock
    input wire logic arst_n, // async reset, low
    input wire logic convStart, // start pulse
    input wire logic [1:0] convChannel, // channel converted
    input wire adc_seq_pkg::route_s [3:0] routes, // input routing
    output logic convDone, // done pulse
    output logic [9:0] convResult // result, garbage outside done
);
    int cnt;
    logic slow;
    logic [9:0] held;
    // result encodes the routed inputs so routing shows up in the result words
    wire logic [9:0] val = {routes[convChannel].posInput, routes[convChannel].negInput,
        convChannel};
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt <= 0;
            slow <= 1'b0;
            convDone <= 1'b0;
            held <= 10'h000;
            convResult <= 10'h3FF;
        end else begin
            convDone <= 1'b0;
            // between pulses the bus is not held: show the inverse of the last value
            convResult <= ~held;
            if (convStart) begin
                cnt <= slow ? 9 : 2;
            end else if (cnt > 1) begin
                cnt <= cnt - 1;
            end else if (cnt == 1) begin
                cnt <= 0;
                convDone <= 1'b1;
                convResult <= val;
                held <= val;
                slow <= ~slow;
            end
        end
    end
endmodule : conv_model

// ---- verification/tb_top.sv ----
// self-checking bench: AHB-Lite master tasks drive the sequencer, conv_model answers
// assumes zero-wait slave; reset held 20 cycles
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, arstN = 0, hsel = 0, hwrite = 0, hready, hresp, convStart, convDone;
    logic [1:0] htrans = 2'h0, convChannel;
    logic [2:0] hsize = 3'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [3:0] sampleHold;
    logic [9:0] convResult;
    adc_seq_pkg::route_s [3:0] routes;
    int numErrors = 0, cmpCount = 0;
    always #5 clk = ~clk;
    adc_sample_convert_sequencer i_adc_sample_convert_sequencer (.clk(clk), .arst_n(arstN),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata),
        .convStart(convStart), .convChannel(convChannel), .convDone(convDone),
        .convResult(convResult), .sampleHold(sampleHold), .routes(routes));
    conv_model i_conv_model (.clk(clk), .arst_n(arstN), .convStart(convStart),
        .convChannel(convChannel), .routes(routes), .convDone(convDone),
        .convResult(convResult));
    task automatic close_out();
        $display("errors=%0d compares=%0d", numErrors, cmpCount);
        if (numErrors == 0 && cmpCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp) begin
            numErrors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // ready and read data are looked at mid-cycle, so they are what the next edge samples
    task automatic wait_ready(output logic [31:0] d);
        int n = 0;
        logic r;
        do begin
            @(negedge clk);
            r = hready;
            d = hrdata;
            @(posedge clk);
            n++;
        end while (r !== 1'b1 && n < 50);
        if (r !== 1'b1) begin
            numErrors++;
            close_out();
        end
    endtask : wait_ready
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        hsize <= 3'b010;
        wait_ready(rd);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready(rd);
    endtask : bus
    // acquire, trigger by clearing acquire, wait for done and clear it
    task automatic seq(input logic [31:0] c);
        int n = 0;
        bus(1'b1, 8'h00, c | 32'h1);
        bus(1'b1, 8'h00, c);
        do begin
            bus(1'b0, 8'h08, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 100);
        chk(rd[1], 1'b1);
        if (rd[1] !== 1'b1) close_out();
        bus(1'b1, 8'h08, 32'h2);
    endtask : seq
    // joint, two channels, alternate sets, split buffer, interrupt every 4 groups
    task automatic scen_alt_split();
        logic [31:0] pat[4] = '{32'h040, 32'h001, 32'h3C0, 32'h0E5};
        logic [31:0] expSt;
        bus(1'b1, 8'h04, 32'h0000_EF01);
        for (int g = 0; g < 2; g++) begin
            for (int s = 0; s < 4; s++) begin
                seq(32'h36C);
                bus(1'b0, 8'h08, 32'h0);
                expSt = s < 3 ? (g ? 32'h4 : 32'h0) : (g ? 32'h1 : 32'h5);
                // set in use flips at every group end, so it is second after odd-numbered groups (even s)
                chk(rd, expSt | (s[0] ? 32'h0 : 32'h10));
            end
            bus(1'b1, 8'h08, 32'h1);
            bus(1'b0, 8'h08, 32'h0);
            chk(rd[0], 1'b0);
        end
        chk(sampleHold, 32'h0);
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 8'h40 + 8'(4 * i), 32'h0);
            chk(rd, pat[i % 4]);
        end
    endtask : scen_alt_split
    // sequential, four channels, auto acquire, first set only, differential channel 0
    task automatic scen_sequential();
        logic [31:0] pat[4] = '{32'h344, 32'h0D9, 32'h11E, 32'h163};
        bus(1'b1, 8'h04, 32'h0000_00BD);
        for (int s = 0; s < 4; s++) seq(32'h312);
        bus(1'b0, 8'h08, 32'h0);
        chk(rd, 32'h1);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h313);
        chk(sampleHold, 32'hF);
        for (int i = 0; i < 4; i++) begin
            bus(1'b0, 8'h40 + 8'(4 * i), 32'h0);
            chk(rd, pat[i]);
        end
        // fifth conversion must land in word 0, leaving word 4 from the split run
        seq(32'h312);
        bus(1'b0, 8'h50, 32'h0);
        chk(rd, 32'h040);
    endtask : scen_sequential
    initial begin
        repeat (20) @(posedge clk);
        arstN <= 1'b1;
        scen_alt_split();
        scen_sequential();
        close_out();
    end
endmodule : tb_top
